// ### logic/gif_pkg.sv
package gif_pkg;
  // Register bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [7:0] OFS_EVENT_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0D;
  // Reset values
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // Flag bit positions
  localparam int BIT_PWM_TIMER_ZERO = 0;
  localparam int BIT_PWM_TIMER_ONE = 1;
  localparam int BIT_PROC = 2;
  localparam int BIT_KEYPAD = 3;
  localparam int BIT_VSYNC = 4;
  localparam int BIT_I2C = 5;
  localparam int BIT_EXTIRQ = 6;
  localparam int BIT_WAKE = 7;
  // Event sources, one pulse or level per source
  typedef struct packed {
    logic wake;
    logic extIrq;
    logic i2c;
    logic vsync;
    logic keypad;
    logic procDone;
    logic pwmOne;
    logic pwmZero;
  } gif_events_s;
  // Register access request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } gif_req_s;
endpackage

// ### logic/gif_irq_flags.sv
// Local design decision: the strobed register port.
module gif_irq_flags
  import gif_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire gif_req_s busReq,
  output logic [DATA_W-1:0] busRdata,
  // Internal event sources, same clock
  input wire gif_events_s evtIn,
  // Pin from outside the clock domain
  input wire logic extIrqPin,
  // Interrupt line to host
  output logic hostIrq
);
  // Pin synchroniser stages and edge history
  logic extSync1_ff;
  logic extSync2_ff;
  logic extPrev_ff;
  // Flag and mask registers
  logic [DATA_W-1:0] flags_ff;
  logic [DATA_W-1:0] nxt_flags;
  logic [DATA_W-1:0] mask_ff;
  logic [DATA_W-1:0] nxt_mask;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic irq_ff;
  // Decode wires
  wire selFlags = busReq.addr == OFS_EVENT_FLAGS;
  wire selMask = busReq.addr == OFS_IRQ_MASK;
  wire wrFlags = busReq.wr && selFlags;
  wire wrMask = busReq.wr && selMask;
  // Rising edge of the synchronised external pin
  wire extRise = extSync2_ff && !extPrev_ff;
  // Source vector in flag layout
  logic [DATA_W-1:0] setVec;
  assign setVec[BIT_WAKE] = evtIn.wake;
  assign setVec[BIT_EXTIRQ] = extRise | evtIn.extIrq;
  assign setVec[BIT_I2C] = evtIn.i2c;
  assign setVec[BIT_VSYNC] = evtIn.vsync;
  assign setVec[BIT_KEYPAD] = evtIn.keypad;
  assign setVec[BIT_PROC] = evtIn.procDone;
  assign setVec[BIT_PWM_TIMER_ONE] = evtIn.pwmOne;
  assign setVec[BIT_PWM_TIMER_ZERO] = evtIn.pwmZero;
  // Clear mask from a write of ones
  wire [DATA_W-1:0] clrVec = wrFlags ? busReq.wdata : RST_FLAGS;
  // Set wins over clear; flags ignore mask
  assign nxt_flags = (flags_ff & ~clrVec) | setVec;
  assign nxt_mask = wrMask ? busReq.wdata : mask_ff;
  // Read mux, unmapped reads zero
  assign nxt_rdata = !busReq.rd ? RD_UNMAPPED :
                     selFlags ? flags_ff :
                     selMask ? mask_ff : RD_UNMAPPED;
  // True when any flag is set and its mask bit is clear
  function automatic logic anyPending(input logic [DATA_W-1:0] f, input logic [DATA_W-1:0] m);
    // Masked bits drop out before the OR
    anyPending = |(f & ~m);
  endfunction
  // Unmasked flags drive the line
  wire irqNext = anyPending(nxt_flags, nxt_mask);
  // Pin synchroniser and edge history
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      extSync1_ff <= 1'b0;
      extSync2_ff <= 1'b0;
      extPrev_ff <= 1'b0;
    end
    else
    begin
      extSync1_ff <= extIrqPin;
      extSync2_ff <= extSync1_ff;
      extPrev_ff <= extSync2_ff;
    end
  end
  // Register state
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      flags_ff <= RST_FLAGS;
      mask_ff <= RST_MASK;
      rdata_ff <= RD_UNMAPPED;
      irq_ff <= 1'b0;
    end
    else
    begin
      flags_ff <= nxt_flags;
      mask_ff <= nxt_mask;
      rdata_ff <= nxt_rdata;
      irq_ff <= irqNext;
    end
  end
  // Outputs from flops
  assign busRdata = rdata_ff;
  assign hostIrq = irq_ff;

  // Checks
  a_clear_on_one: assert property (@(posedge core_clk) disable iff (rst)
    (wrFlags && busReq.wdata[BIT_WAKE] && !evtIn.wake) |=> !flags_ff[BIT_WAKE])
    else $error("flag not cleared by write of one");
  a_zero_keeps: assert property (@(posedge core_clk) disable iff (rst)
    (wrFlags && !busReq.wdata[BIT_I2C] && flags_ff[BIT_I2C]) |=> flags_ff[BIT_I2C])
    else $error("flag lost on write of zero");
  a_wake_set: assert property (@(posedge core_clk) disable iff (rst)
    evtIn.wake |=> flags_ff[BIT_WAKE])
    else $error("wake flag not set");
  a_ext_set: assert property (@(posedge core_clk) disable iff (rst)
    extRise |=> flags_ff[BIT_EXTIRQ])
    else $error("pin flag not set");
  a_i2c_set: assert property (@(posedge core_clk) disable iff (rst)
    evtIn.i2c |=> flags_ff[BIT_I2C])
    else $error("i2c flag not set");
  a_vsync_set: assert property (@(posedge core_clk) disable iff (rst)
    evtIn.vsync |=> flags_ff[BIT_VSYNC])
    else $error("vsync flag not set");
  a_keypad_set: assert property (@(posedge core_clk) disable iff (rst)
    evtIn.keypad |=> flags_ff[BIT_KEYPAD])
    else $error("keypad flag not set");
  a_proc_set: assert property (@(posedge core_clk) disable iff (rst)
    evtIn.procDone |=> flags_ff[BIT_PROC])
    else $error("process flag not set");
  a_pwm_one: assert property (@(posedge core_clk) disable iff (rst)
    evtIn.pwmOne |=> flags_ff[BIT_PWM_TIMER_ONE])
    else $error("pwm one flag not set");
  a_pwm_zero: assert property (@(posedge core_clk) disable iff (rst)
    evtIn.pwmZero |=> flags_ff[BIT_PWM_TIMER_ZERO])
    else $error("pwm zero flag not set");
  a_mask_write: assert property (@(posedge core_clk) disable iff (rst)
    wrMask |=> mask_ff == $past(busReq.wdata))
    else $error("mask write lost");
  a_irq_masked: assert property (@(posedge core_clk) disable iff (rst)
    hostIrq |-> |(flags_ff & ~mask_ff))
    else $error("interrupt from masked flag");
  a_irq_raised: assert property (@(posedge core_clk) disable iff (rst)
    |(flags_ff & ~mask_ff) |-> hostIrq)
    else $error("unmasked flag without interrupt");
  a_sticky_flag: assert property (@(posedge core_clk) disable iff (rst)
    (flags_ff[BIT_VSYNC] && !wrFlags) |=> flags_ff[BIT_VSYNC])
    else $error("flag dropped without clear");
  a_read_data: assert property (@(posedge core_clk) disable iff (rst)
    (busReq.rd && selFlags) |=> busRdata == $past(flags_ff))
    else $error("flag read data wrong");
  c_masked_event: cover property (@(posedge core_clk) disable iff (rst)
    evtIn.vsync && mask_ff[BIT_VSYNC]);
  c_set_and_clear: cover property (@(posedge core_clk) disable iff (rst)
    wrFlags && |(busReq.wdata & setVec));
  c_irq_rise: cover property (@(posedge core_clk) disable iff (rst) $rose(hostIrq));
  c_pin_event: cover property (@(posedge core_clk) disable iff (rst) extRise);
  // Mask write followed at once by a read
  c_back_to_back: cover property (@(posedge core_clk) disable iff (rst)
    wrMask ##1 busReq.rd);

  // Wakeup flag, bit 7
  a_clear_wake: assert property (@(posedge core_clk) disable iff (rst)
    (wrFlags && busReq.wdata[BIT_WAKE] && !setVec[BIT_WAKE]) |=> !flags_ff[BIT_WAKE])
    else $error("wake flag not cleared");
  a_keep_wake: assert property (@(posedge core_clk) disable iff (rst)
    (flags_ff[BIT_WAKE] && !(wrFlags && busReq.wdata[BIT_WAKE])) |=> flags_ff[BIT_WAKE])
    else $error("wake flag dropped");
  a_masked_wake: assert property (@(posedge core_clk) disable iff (rst)
    (mask_ff[BIT_WAKE] && !anyPending(flags_ff, mask_ff)) |-> !hostIrq)
    else $error("masked wake flag raised line");
  a_line_wake: assert property (@(posedge core_clk) disable iff (rst)
    (flags_ff[BIT_WAKE] && !mask_ff[BIT_WAKE]) |-> hostIrq)
    else $error("wake flag without line");

  // Pin flag, bit 6
  a_clear_ext: assert property (@(posedge core_clk) disable iff (rst)
    (wrFlags && busReq.wdata[BIT_EXTIRQ] && !setVec[BIT_EXTIRQ]) |=> !flags_ff[BIT_EXTIRQ])
    else $error("pin flag not cleared");
  a_keep_ext: assert property (@(posedge core_clk) disable iff (rst)
    (flags_ff[BIT_EXTIRQ] && !(wrFlags && busReq.wdata[BIT_EXTIRQ])) |=> flags_ff[BIT_EXTIRQ])
    else $error("pin flag dropped");
  a_masked_ext: assert property (@(posedge core_clk) disable iff (rst)
    (mask_ff[BIT_EXTIRQ] && !anyPending(flags_ff, mask_ff)) |-> !hostIrq)
    else $error("masked pin flag raised line");
  a_line_ext: assert property (@(posedge core_clk) disable iff (rst)
    (flags_ff[BIT_EXTIRQ] && !mask_ff[BIT_EXTIRQ]) |-> hostIrq)
    else $error("pin flag without line");

  // I2C flag, bit 5
  a_clear_i2c: assert property (@(posedge core_clk) disable iff (rst)
    (wrFlags && busReq.wdata[BIT_I2C] && !setVec[BIT_I2C]) |=> !flags_ff[BIT_I2C])
    else $error("i2c flag not cleared");
  a_keep_i2c: assert property (@(posedge core_clk) disable iff (rst)
    (flags_ff[BIT_I2C] && !(wrFlags && busReq.wdata[BIT_I2C])) |=> flags_ff[BIT_I2C])
    else $error("i2c flag dropped");
  a_masked_i2c: assert property (@(posedge core_clk) disable iff (rst)
    (mask_ff[BIT_I2C] && !anyPending(flags_ff, mask_ff)) |-> !hostIrq)
    else $error("masked i2c flag raised line");
  a_line_i2c: assert property (@(posedge core_clk) disable iff (rst)
    (flags_ff[BIT_I2C] && !mask_ff[BIT_I2C]) |-> hostIrq)
    else $error("i2c flag without line");

  // Vertical sync flag, bit 4
  a_clear_vsync: assert property (@(posedge core_clk) disable iff (rst)
    (wrFlags && busReq.wdata[BIT_VSYNC] && !setVec[BIT_VSYNC]) |=> !flags_ff[BIT_VSYNC])
    else $error("vsync flag not cleared");
  a_keep_vsync: assert property (@(posedge core_clk) disable iff (rst)
    (flags_ff[BIT_VSYNC] && !(wrFlags && busReq.wdata[BIT_VSYNC])) |=> flags_ff[BIT_VSYNC])
    else $error("vsync flag dropped");
  a_masked_vsync: assert property (@(posedge core_clk) disable iff (rst)
    (mask_ff[BIT_VSYNC] && !anyPending(flags_ff, mask_ff)) |-> !hostIrq)
    else $error("masked vsync flag raised line");
  a_line_vsync: assert property (@(posedge core_clk) disable iff (rst)
    (flags_ff[BIT_VSYNC] && !mask_ff[BIT_VSYNC]) |-> hostIrq)
    else $error("vsync flag without line");

  // Keypad flag, bit 3
  a_clear_keypad: assert property (@(posedge core_clk) disable iff (rst)
    (wrFlags && busReq.wdata[BIT_KEYPAD] && !setVec[BIT_KEYPAD]) |=> !flags_ff[BIT_KEYPAD])
    else $error("keypad flag not cleared");
  a_keep_keypad: assert property (@(posedge core_clk) disable iff (rst)
    (flags_ff[BIT_KEYPAD] && !(wrFlags && busReq.wdata[BIT_KEYPAD])) |=> flags_ff[BIT_KEYPAD])
    else $error("keypad flag dropped");
  a_masked_keypad: assert property (@(posedge core_clk) disable iff (rst)
    (mask_ff[BIT_KEYPAD] && !anyPending(flags_ff, mask_ff)) |-> !hostIrq)
    else $error("masked keypad flag raised line");
  a_line_keypad: assert property (@(posedge core_clk) disable iff (rst)
    (flags_ff[BIT_KEYPAD] && !mask_ff[BIT_KEYPAD]) |-> hostIrq)
    else $error("keypad flag without line");

  // Process completion flag, bit 2
  a_clear_proc: assert property (@(posedge core_clk) disable iff (rst)
    (wrFlags && busReq.wdata[BIT_PROC] && !setVec[BIT_PROC]) |=> !flags_ff[BIT_PROC])
    else $error("process flag not cleared");
  a_keep_proc: assert property (@(posedge core_clk) disable iff (rst)
    (flags_ff[BIT_PROC] && !(wrFlags && busReq.wdata[BIT_PROC])) |=> flags_ff[BIT_PROC])
    else $error("process flag dropped");
  a_masked_proc: assert property (@(posedge core_clk) disable iff (rst)
    (mask_ff[BIT_PROC] && !anyPending(flags_ff, mask_ff)) |-> !hostIrq)
    else $error("masked process flag raised line");
  a_line_proc: assert property (@(posedge core_clk) disable iff (rst)
    (flags_ff[BIT_PROC] && !mask_ff[BIT_PROC]) |-> hostIrq)
    else $error("process flag without line");

  // Timer one flag, bit 1
  a_clear_pwmone: assert property (@(posedge core_clk) disable iff (rst)
    (wrFlags && busReq.wdata[BIT_PWM_TIMER_ONE] && !setVec[BIT_PWM_TIMER_ONE]) |=> !flags_ff[BIT_PWM_TIMER_ONE])
    else $error("pwm one flag not cleared");
  a_keep_pwmone: assert property (@(posedge core_clk) disable iff (rst)
    (flags_ff[BIT_PWM_TIMER_ONE] && !(wrFlags && busReq.wdata[BIT_PWM_TIMER_ONE])) |=> flags_ff[BIT_PWM_TIMER_ONE])
    else $error("pwm one flag dropped");
  a_masked_pwmone: assert property (@(posedge core_clk) disable iff (rst)
    (mask_ff[BIT_PWM_TIMER_ONE] && !anyPending(flags_ff, mask_ff)) |-> !hostIrq)
    else $error("masked pwm one flag raised line");
  a_line_pwmone: assert property (@(posedge core_clk) disable iff (rst)
    (flags_ff[BIT_PWM_TIMER_ONE] && !mask_ff[BIT_PWM_TIMER_ONE]) |-> hostIrq)
    else $error("pwm one flag without line");

  // Timer zero flag, bit 0
  a_clear_pwmzero: assert property (@(posedge core_clk) disable iff (rst)
    (wrFlags && busReq.wdata[BIT_PWM_TIMER_ZERO] && !setVec[BIT_PWM_TIMER_ZERO]) |=> !flags_ff[BIT_PWM_TIMER_ZERO])
    else $error("pwm zero flag not cleared");
  a_keep_pwmzero: assert property (@(posedge core_clk) disable iff (rst)
    (flags_ff[BIT_PWM_TIMER_ZERO] && !(wrFlags && busReq.wdata[BIT_PWM_TIMER_ZERO])) |=> flags_ff[BIT_PWM_TIMER_ZERO])
    else $error("pwm zero flag dropped");
  a_masked_pwmzero: assert property (@(posedge core_clk) disable iff (rst)
    (mask_ff[BIT_PWM_TIMER_ZERO] && !anyPending(flags_ff, mask_ff)) |-> !hostIrq)
    else $error("masked pwm zero flag raised line");
  a_line_pwmzero: assert property (@(posedge core_clk) disable iff (rst)
    (flags_ff[BIT_PWM_TIMER_ZERO] && !mask_ff[BIT_PWM_TIMER_ZERO]) |-> hostIrq)
    else $error("pwm zero flag without line");

  // Mask read returns the stored mask
  a_mask_read: assert property (@(posedge core_clk) disable iff (rst)
    (busReq.rd && selMask) |=> busRdata == $past(mask_ff))
    else $error("mask read data wrong");
  // Read data idles at zero
  a_rdata_idle: assert property (@(posedge core_clk) disable iff (rst)
    !busReq.rd |=> busRdata == RD_UNMAPPED)
    else $error("read data not idle");
  // Unmapped reads return zero
  a_rdata_unmapped: assert property (@(posedge core_clk) disable iff (rst)
    (busReq.rd && !selFlags && !selMask) |=> busRdata == RD_UNMAPPED)
    else $error("unmapped read not zero");

  // Mask only changes on its own write
  a_mask_hold: assert property (@(posedge core_clk) disable iff (rst)
    !wrMask |=> mask_ff == $past(mask_ff))
    else $error("mask changed without write");
  // Flag clears leave the mask alone
  a_flag_wr_mask: assert property (@(posedge core_clk) disable iff (rst)
    wrFlags |=> mask_ff == $past(mask_ff))
    else $error("flag write touched mask");

  // Event in the clear cycle wins
  a_set_wins: assert property (@(posedge core_clk) disable iff (rst)
    (wrFlags && busReq.wdata[BIT_VSYNC] && evtIn.vsync) |=> flags_ff[BIT_VSYNC])
    else $error("clear beat event");
  // Clear of all bits with no event empties the register
  a_clear_all: assert property (@(posedge core_clk) disable iff (rst)
    (wrFlags && busReq.wdata == '1 && setVec == RST_FLAGS) |=> flags_ff == RST_FLAGS)
    else $error("flags not all cleared");
  // Steady pin level never sets the flag again
  a_pin_level: assert property (@(posedge core_clk) disable iff (rst)
    (!extRise && !evtIn.extIrq && !flags_ff[BIT_EXTIRQ]) |=> !flags_ff[BIT_EXTIRQ])
    else $error("pin flag set without edge");

  // Registers sit at reset values while reset is high
  a_reset_vals: assert property (@(posedge core_clk)
    rst |-> (flags_ff == RST_FLAGS && mask_ff == RST_MASK && !hostIrq))
    else $error("reset values wrong");
endmodule // gif_irq_flags

// ### tb/gif_host.sv
module gif_host
  import gif_pkg::*;
(
  // Bus side
  input wire logic core_clk,
  output gif_req_s busReq,
  input wire logic [DATA_W-1:0] busRdata,
  // Interrupt line
  input wire logic hostIrq
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus from time zero
  initial busReq = '0;
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    busReq <= '0;
  endtask
  // Read data is valid only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    busReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk);
    busReq <= '0;
    #1 d = busRdata;
  endtask
  // Source lookup when the line is up
  task automatic service(output logic [7:0] d);
    if (hostIrq === 1'b1) rd(OFS_EVENT_FLAGS, d);
    else d = 8'h00;
  endtask
endmodule // gif_host

// ### tb/tb.sv
module tb;
  import gif_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0;
  logic rst = 1;
  gif_req_s busReq;
  logic [7:0] busRdata;
  gif_events_s evtIn = '0;
  logic extIrqPin = 0;
  logic hostIrq;
  logic [7:0] d;
  int fail_count = 0;
  int tests_run = 0;
  // About 167 MHz clock: the 2.5 ns half period rounds to 3 ns
  always #2.5 core_clk = ~core_clk;
  gif_irq_flags uut (.core_clk(core_clk), .rst(rst), .busReq(busReq), .busRdata(busRdata),
    .evtIn(evtIn), .extIrqPin(extIrqPin), .hostIrq(hostIrq));
  gif_host host (.core_clk(core_clk), .busReq(busReq), .busRdata(busRdata), .hostIrq(hostIrq));
  // Verdict and end of run
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Compare and count
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // One-cycle event pulse
  task automatic pulse(input logic [7:0] v);
    @(posedge core_clk);
    evtIn <= gif_events_s'(v);
    @(posedge core_clk);
    evtIn <= '0;
  endtask
  // Reset values and unmapped place
  task automatic t_reset;
    host.rd(OFS_EVENT_FLAGS, d);
    chk("flags", d, 8'h00);
    host.rd(OFS_IRQ_MASK, d);
    chk("mask", d, 8'h00);
    host.wr(8'h0E, 8'hFF);
    host.rd(8'h0E, d);
    chk("unmapped", d, 8'h00);
  endtask
  // Every source sets its own bit; zero keeps, one clears
  task automatic t_sources;
    for (int i = 0; i < 8; i++)
    begin
      pulse(8'h01 << i);
      host.wr(OFS_EVENT_FLAGS, ~(8'h01 << i));
      host.service(d);
      chk("flag", d, 8'h01 << i);
      host.wr(OFS_EVENT_FLAGS, 8'h01 << i);
      host.rd(OFS_EVENT_FLAGS, d);
      chk("cleared", d, 8'h00);
      chk("cleared irq", {7'h00, hostIrq}, 8'h00);
    end
  endtask
  // Masked flags latch but stay off the line
  task automatic t_mask;
    host.wr(OFS_IRQ_MASK, 8'hFF);
    host.rd(OFS_IRQ_MASK, d);
    chk("mask rw", d, 8'hFF);
    pulse(8'hFF);
    host.rd(OFS_EVENT_FLAGS, d);
    chk("masked flags", d, 8'hFF);
    chk("masked irq", {7'h00, hostIrq}, 8'h00);
    host.wr(OFS_IRQ_MASK, 8'hEF);
    #1 chk("unmasked irq", {7'h00, hostIrq}, 8'h01);
    host.wr(OFS_EVENT_FLAGS, 8'hFF);
    #1 chk("irq clear", {7'h00, hostIrq}, 8'h00);
    host.wr(OFS_IRQ_MASK, 8'h00);
  endtask
  // Pin edge reaches bit 6, level alone does not set it again
  task automatic t_pin;
    int n;
    @(posedge core_clk);
    extIrqPin <= 1'b1;
    for (n = 0; n < 8 && hostIrq !== 1'b1; n++) @(posedge core_clk);
    if (n == 8) chk("pin wait", 8'h00, 8'h01);
    if (n == 8) final_report;
    host.rd(OFS_EVENT_FLAGS, d);
    chk("pin flag", d, 8'h40);
    host.wr(OFS_EVENT_FLAGS, 8'h40);
    host.rd(OFS_EVENT_FLAGS, d);
    chk("pin clear", d, 8'h00);
    @(posedge core_clk);
    extIrqPin <= 1'b0;
  endtask
  // Event and clear in one cycle, then reset in mid-run
  task automatic t_rerst;
    fork
      host.wr(OFS_EVENT_FLAGS, 8'h10);
      pulse(8'h10);
    join
    host.rd(OFS_EVENT_FLAGS, d);
    chk("set wins", d, 8'h10);
    host.wr(OFS_IRQ_MASK, 8'h0F);
    pulse(8'h81);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    host.rd(OFS_EVENT_FLAGS, d);
    chk("flags after reset", d, 8'h00);
    host.rd(OFS_IRQ_MASK, d);
    chk("mask after reset", d, 8'h00);
    chk("irq after reset", {7'h00, hostIrq}, 8'h00);
  endtask
  // Main sequence
  initial
  begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    t_reset;
    t_sources;
    t_mask;
    t_pin;
    t_rerst;
    final_report;
  end
endmodule // tb
